/* rtl/sspc_pkg.sv */
package sspc_pkg;
	// ****************************************
	// pins and ports
	// ****************************************
	localparam int NUM_PORTS     = 4;
	localparam int UPSTREAM_PORT = 0;
	localparam int GPIO_W        = 11;
	localparam int GPIO_RST_P2   = 0;
	localparam int GPIO_IRQ0     = 2;
	localparam int GPIO_EVENT    = 7;
	localparam int GPIO_RST_P1   = 8;
	localparam int GPIO_RST_P3   = 9;
	localparam logic [GPIO_W-1:0] GPIO_USED = 11'h787;
	// ****************************************
	// modes
	// ****************************************
	localparam int MODE_W = 3;
	localparam logic [MODE_W-1:0] MODE_NORMAL = 3'h0;
	localparam logic [MODE_W-1:0] MODE_EEPROM = 3'h1;
	// ****************************************
	// smbus
	// ****************************************
	localparam logic [6:0] SMB_MASTER_ADDR = 7'h50;
	localparam logic [6:0] SMB_SLAVE_ADDR  = 7'h77;
	localparam int CLK_HZ     = 125000000;
	localparam int SMB_HZ     = 400000;
	// half period of scl, rounded down so the bus never runs slower than asked
	localparam int SMB_HALF   = CLK_HZ / (2 * SMB_HZ);
	localparam int SMB_CNT_W  = 8;
	// ****************************************
	// fundamental reset sequence
	// ****************************************
	localparam int LINK_RST_NS  = 1000;
	localparam int LINK_RST_CYC = (LINK_RST_NS * 125 + 999) / 1000;
	localparam int LRST_W       = 8;
endpackage

/* rtl/sspc_top.sv */
`timescale 1ns/1ps
`default_nettype none
// How it works
// - names ending _n, and resetn, are asserted low; all others asserted high
// - master smbus clock toggles at 400 KHz while this device is master
// - port 0 is the upstream port; ports 1..3 downstream
// - gpio 0, 8, 9 alternate: reset out for ports 2, 1, 3
// - gpio 2 alternate: active-low expander interrupt 0 input
// - gpio 7 alternate: active-low event output
// - reset loads downstream common-clock strap into downstream slot clock bits
// - software write overrides each port's slot clock bit independently
// - reset loads upstream common-clock strap into upstream slot clock bit
// - fundamental reset clears all logic but the gpio input register, drives master scl and the registered reset flag high, and starts link reset sequence
// - mode strap: 0 normal, 1 normal with eeprom init, 2..7 reserved
// - master smbus address 0x50, slave address 0x77
// - expander interrupt triggers master smbus read of hot-plug inputs
module sspc_top
	import sspc_pkg::*;
(
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 resetn,
	input  wire logic                 fundamental_reset_in_n,
	// straps
	input  wire logic [MODE_W-1:0]    operating_mode_strap,
	input  wire logic                 common_clock_downstream_strap,
	input  wire logic                 common_clock_upstream_strap,
	// slot clock configuration bit control
	input  wire logic [NUM_PORTS-1:0] sclk_wr,
	input  wire logic [NUM_PORTS-1:0] sclk_wdata,
	output logic [NUM_PORTS-1:0]      sclk_status,
	output logic                      upstream_sclk,
	output logic [NUM_PORTS-1:0]      port_is_upstream,
	// mode status
	output logic                      mode_normal,
	output logic                      mode_eeprom_init,
	output logic                      mode_reserved,
	output logic [6:0]                smb_master_addr,
	output logic [6:0]                smb_slave_addr,
	// gpio control
	input  wire logic [GPIO_W-1:0]    gpio_alt_en,
	input  wire logic [GPIO_W-1:0]    gpio_out,
	input  wire logic [GPIO_W-1:0]    gpio_dir,
	input  wire logic [NUM_PORTS-1:0] port_reset_req,
	input  wire logic                 event_req,
	output logic [GPIO_W-1:0]         gpio_in_val,
	// gpio pins
	input  wire logic [GPIO_W-1:0]    gpio_pin_i,
	output logic [GPIO_W-1:0]         gpio_pin_o,
	output logic [GPIO_W-1:0]         gpio_pin_oe,
	// expander and link reset
	output logic                      expander_irq_seen,
	output logic                      expander_read_req,
	input  wire logic                 expander_read_done,
	input  wire logic                 smb_master_active,
	output logic                      master_smbus_clock_o,
	output logic                      link_reset_active
);
	// ****************************************
	// reset and strap capture
	// ****************************************
	logic                 rst_busy;
	logic                 frst_r, frst_nxt;
	logic                 cap_r, cap_nxt;
	logic [MODE_W-1:0]    mode_r, mode_nxt;
	logic [NUM_PORTS-1:0] sclk_r, sclk_nxt;
	logic [LRST_W-1:0]    lrst_r, lrst_nxt;

	assign rst_busy = ~fundamental_reset_in_n;

	function automatic logic [NUM_PORTS-1:0] strap_seed(input logic ds, input logic us);
		logic [NUM_PORTS-1:0] v;
		v = {NUM_PORTS{ds}};
		v[UPSTREAM_PORT] = us;
		return v;
	endfunction

	always_comb begin
		frst_nxt = rst_busy;
		cap_nxt  = cap_r;
		mode_nxt = mode_r;
		sclk_nxt = sclk_r;
		lrst_nxt = lrst_r;
		if (rst_busy) begin
			cap_nxt  = 1'b0;
			mode_nxt = MODE_NORMAL;
			sclk_nxt = '0;
			lrst_nxt = '0;
		end else if (!cap_r) begin
			cap_nxt  = 1'b1;
			mode_nxt = operating_mode_strap;
			sclk_nxt = strap_seed(common_clock_downstream_strap, common_clock_upstream_strap);
			lrst_nxt = LRST_W'(LINK_RST_CYC);
		end else begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				if (sclk_wr[i]) begin
					sclk_nxt[i] = sclk_wdata[i];
				end
			end
			if (lrst_r != '0) begin
				lrst_nxt = lrst_r - 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			frst_r <= 1'b1;
			cap_r  <= 1'b0;
			mode_r <= MODE_NORMAL;
			sclk_r <= '0;
			lrst_r <= '0;
		end else begin
			frst_r <= frst_nxt;
			cap_r  <= cap_nxt;
			mode_r <= mode_nxt;
			sclk_r <= sclk_nxt;
			lrst_r <= lrst_nxt;
		end
	end

	assign sclk_status   = sclk_r;
	assign upstream_sclk    = sclk_r[UPSTREAM_PORT];
	assign port_is_upstream = NUM_PORTS'(1) << UPSTREAM_PORT;
	assign mode_normal      = cap_r && (mode_r == MODE_NORMAL);
	assign mode_eeprom_init = cap_r && (mode_r == MODE_EEPROM);
	assign mode_reserved    = cap_r && (mode_r > MODE_EEPROM);
	assign smb_master_addr  = SMB_MASTER_ADDR;
	assign smb_slave_addr   = SMB_SLAVE_ADDR;
	assign link_reset_active = frst_r || !cap_r || (lrst_r != '0);

	// ****************************************
	// gpio mux
	// ****************************************
	logic [GPIO_W-1:0] alt_o, alt_oe, alt_en;
	logic              irq_n;

	always_comb begin
		alt_en = gpio_alt_en & GPIO_USED;
		alt_o  = gpio_out;
		alt_oe = gpio_dir;
		alt_o[GPIO_RST_P2] = ~(port_reset_req[2] | link_reset_active);
		alt_o[GPIO_RST_P1] = ~(port_reset_req[1] | link_reset_active);
		alt_o[GPIO_RST_P3] = ~(port_reset_req[3] | link_reset_active);
		alt_o[GPIO_EVENT]  = ~event_req;
		alt_o[GPIO_IRQ0]   = 1'b0;
		alt_oe[GPIO_RST_P2] = 1'b1;
		alt_oe[GPIO_RST_P1] = 1'b1;
		alt_oe[GPIO_RST_P3] = 1'b1;
		alt_oe[GPIO_EVENT]  = 1'b1;
		alt_oe[GPIO_IRQ0]   = 1'b0;
	end

	logic [GPIO_W-1:0] po_r, po_nxt, poe_r, poe_nxt;
	logic [GPIO_W-1:0] gin_r;
	logic              irq_d_r, irq_nxt;
	logic              req_r, req_nxt;

	always_comb begin
		for (int i = 0; i < GPIO_W; i++) begin
			po_nxt[i]  = alt_en[i] ? alt_o[i] : gpio_out[i];
			poe_nxt[i] = alt_en[i] ? alt_oe[i] : gpio_dir[i];
		end
		if (rst_busy) begin
			po_nxt  = '0;
			poe_nxt = '0;
		end
	end

	// active-low irq sampled only when alternate enabled
	assign irq_n   = alt_en[GPIO_IRQ0] ? gpio_pin_i[GPIO_IRQ0] : 1'b1;
	assign irq_nxt = rst_busy ? 1'b0 : ~irq_n;

	always_comb begin
		req_nxt = req_r;
		// irq starts expander read; new event wins over done
		if (rst_busy) begin
			req_nxt = 1'b0;
		end else if (~irq_n && !irq_d_r && cap_r) begin
			req_nxt = 1'b1;
		end else if (expander_read_done) begin
			req_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			po_r    <= '0;
			poe_r   <= '0;
			gin_r   <= '0;
			irq_d_r <= 1'b0;
			req_r   <= 1'b0;
		end else begin
			po_r    <= po_nxt;
			poe_r   <= poe_nxt;
			gin_r   <= gpio_pin_i;
			irq_d_r <= irq_nxt;
			req_r   <= req_nxt;
		end
	end

	assign gpio_pin_o        = po_r;
	assign gpio_pin_oe       = poe_r;
	assign gpio_in_val       = gin_r;
	assign expander_irq_seen = irq_d_r;
	assign expander_read_req = req_r;

	// ****************************************
	// master smbus clock generator
	// ****************************************
	logic [SMB_CNT_W-1:0] scnt_r, scnt_nxt;
	logic                 scl_r, scl_nxt;

	always_comb begin
		scnt_nxt = scnt_r;
		scl_nxt  = scl_r;
		// 400 KHz bus clock while master
		if (rst_busy || !smb_master_active) begin
			scnt_nxt = '0;
			scl_nxt  = 1'b1;
		end else if (scnt_r == SMB_CNT_W'(SMB_HALF - 1)) begin
			scnt_nxt = '0;
			scl_nxt  = ~scl_r;
		end else begin
			scnt_nxt = scnt_r + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			scnt_r <= '0;
			scl_r  <= 1'b1;
		end else begin
			scnt_r <= scnt_nxt;
			scl_r  <= scl_nxt;
		end
	end

	assign master_smbus_clock_o = scl_r;

	// ****************************************
	// checks
	// ****************************************
	// strap held after capture
	property p_strap_hold;
		@(posedge clk) disable iff (!resetn || rst_busy)
		cap_r && $past(cap_r) |-> $stable(mode_r);
	endproperty
	a_strap_hold: assert property (p_strap_hold) else $error("mode changed after capture");

	property p_ds_seed;
		@(posedge clk) disable iff (!resetn || rst_busy)
		!cap_r ##1 cap_r |-> sclk_r[1] == $past(common_clock_downstream_strap)
			&& sclk_r[2] == $past(common_clock_downstream_strap)
			&& sclk_r[3] == $past(common_clock_downstream_strap);
	endproperty
	a_ds_seed: assert property (p_ds_seed) else $error("downstream seed wrong");

	property p_us_seed;
		@(posedge clk) disable iff (!resetn || rst_busy)
		!cap_r ##1 cap_r |-> sclk_r[0] == $past(common_clock_upstream_strap);
	endproperty
	a_us_seed: assert property (p_us_seed) else $error("upstream seed wrong");

	property p_override;
		@(posedge clk) disable iff (!resetn || rst_busy)
		cap_r && sclk_wr[2] |=> sclk_r[2] == $past(sclk_wdata[2]);
	endproperty
	a_override: assert property (p_override) else $error("sclk override lost");

	sequence s_rel;
		rst_busy ##1 !rst_busy;
	endsequence
	property p_lrst;
		@(posedge clk) disable iff (!resetn)
		s_rel |-> link_reset_active [*3];
	endproperty
	a_lrst: assert property (p_lrst) else $error("link reset not held");

	// port 1 reset output low during link reset
	property p_rstout;
		@(posedge clk) disable iff (!resetn)
		alt_en[GPIO_RST_P1] && link_reset_active && !rst_busy |=> !gpio_pin_o[GPIO_RST_P1] && gpio_pin_oe[GPIO_RST_P1];
	endproperty
	a_rstout: assert property (p_rstout) else $error("port1 reset not driven");

	// irq pin never driven when alternate
	property p_irqin;
		@(posedge clk) disable iff (!resetn)
		alt_en[GPIO_IRQ0] |=> !gpio_pin_oe[GPIO_IRQ0];
	endproperty
	a_irqin: assert property (p_irqin) else $error("irq pin driven");

	property p_event;
		@(posedge clk) disable iff (!resetn || rst_busy)
		alt_en[GPIO_EVENT] && event_req |=> !gpio_pin_o[GPIO_EVENT];
	endproperty
	a_event: assert property (p_event) else $error("event not driven");

	// irq falling edge raises read request
	property p_exp;
		@(posedge clk) disable iff (!resetn || rst_busy)
		cap_r && alt_en[GPIO_IRQ0] && !gpio_pin_i[GPIO_IRQ0] && !irq_d_r |=> expander_read_req;
	endproperty
	a_exp: assert property (p_exp) else $error("expander read not requested");

	property p_scl;
		@(posedge clk) disable iff (!resetn || rst_busy || !smb_master_active)
		$changed(scl_r) && smb_master_active |-> ##156 $changed(scl_r);
	endproperty
	a_scl: assert property (p_scl) else $error("scl period wrong");
endmodule
`default_nettype wire

/* tb/sspc_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module sspc_partner (
	// clock and reset
	input  wire logic clk,
	input  wire logic resetn,
	// bench control
	input  wire logic irq_cmd,
	input  wire logic slow,
	// expander side
	input  wire logic read_req,
	output logic      irq_pin_n,
	output var logic  read_done
);
	logic [4:0] cnt;
	assign irq_pin_n = ~irq_cmd;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt <= 5'h0;
			read_done <= 1'b0;
		end else begin
			read_done <= 1'b0;
			if (!read_req) begin
				cnt <= 5'h0;
			end else if (cnt == (slow ? 5'h14 : 5'h1)) begin
				read_done <= 1'b1;
				cnt <= 5'h1f;
			end else if (cnt != 5'h1f) begin
				cnt <= cnt + 5'h1;
			end
		end
	end
endmodule
`default_nettype wire

/* tb/switch_strap_reset_pin_config_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module switch_strap_reset_pin_config_tb_top
	import sspc_pkg::*;
;
	logic        clk, resetn, frst_n, ds, us, act, ev, irq_cmd, slow, done, ipn;
	logic        ups, mn, me, mr, irqs, rreq, scl, lra;
	logic [2:0]  mode;
	logic [3:0]  wr, wd, req, es, st, pup;
	logic [6:0]  ma, sa;
	logic [10:0] alt, gout, gdir, ext, pin_i, o, oe, inv;
	logic [21:0] g;
	int          miscompares, n_tests, k;
	assign pin_i = (oe & o) | (~oe & {ext[10:3], ipn, ext[1:0]});
	sspc_top dut (.clk(clk), .resetn(resetn), .fundamental_reset_in_n(frst_n),
		.operating_mode_strap(mode), .common_clock_downstream_strap(ds),
		.common_clock_upstream_strap(us), .sclk_wr(wr), .sclk_wdata(wd), .sclk_status(st),
		.upstream_sclk(ups), .port_is_upstream(pup), .mode_normal(mn), .mode_eeprom_init(me),
		.mode_reserved(mr), .smb_master_addr(ma), .smb_slave_addr(sa), .gpio_alt_en(alt),
		.gpio_out(gout), .gpio_dir(gdir), .port_reset_req(req), .event_req(ev),
		.gpio_in_val(inv), .gpio_pin_i(pin_i), .gpio_pin_o(o), .gpio_pin_oe(oe),
		.expander_irq_seen(irqs), .expander_read_req(rreq), .expander_read_done(done),
		.smb_master_active(act), .master_smbus_clock_o(scl), .link_reset_active(lra));
	sspc_partner far (.clk(clk), .resetn(resetn), .irq_cmd(irq_cmd), .slow(slow),
		.read_req(rreq), .irq_pin_n(ipn), .read_done(done));
	// ****
	// bench helpers
	// ****
	function automatic logic [21:0] gexp(input logic [10:0] a, d, v, input logic [3:0] r, input logic e);
		logic [10:0] m, ao;
		m = a & 11'h385;
		ao = {1'b0, ~r[3], ~r[1], ~e, 4'h0, 2'h0, ~r[2]};
		return {(d & ~m) | (m & 11'h381), (v & ~m) | (ao & m)};
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wait_req(input logic v);
		for (int n = 0; n < 40 && rreq !== v; n++) @(negedge clk);
		chk(rreq, v);
	endtask
	task automatic gap(output int n);
		logic s;
		s = scl;
		for (n = 0; n < 400 && scl === s; n++) @(negedge clk);
	endtask
	task automatic end_sim;
		$display("miscompares %0d n_tests %0d", miscompares, n_tests);
		if (miscompares == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		end_sim;
	end
	// ****
	// scenarios
	// ****
	initial begin
		{resetn, frst_n, ds, us, act, ev, irq_cmd, slow} = 8'h0;
		{mode, wr, wd, req, alt, gout, gdir, ext} = '0;
		void'($urandom(32'h61da));
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		alt <= 11'h385;
		for (k = 0; k < 8; k++) begin
			@(posedge clk);
			frst_n <= 1'b0;
			mode <= 3'(k);
			ds <= 1'($urandom);
			us <= 1'($urandom);
			repeat (2) @(posedge clk);
			frst_n <= 1'b1;
			@(negedge clk);
			chk({mn, me, mr}, 3'h0);
			@(negedge clk);
			chk(lra, 1'b1);
			chk(o & 11'h301, 11'h0);
			repeat (2) @(negedge clk);
			chk(st, {ds, ds, ds, us});
			chk(ups, us);
			chk({mn, me, mr}, {k == 0, k == 1, k > 1});
			chk(pup, 4'h1);
			chk({ma, sa}, {7'h50, 7'h77});
		end
		// link reset ends exactly LINK_RST_CYC clocks after the capture edge
		repeat (LINK_RST_CYC - 3) @(negedge clk);
		chk(lra, 1'b1);
		@(negedge clk);
		chk(lra, 1'b0);
		es = {ds, ds, ds, us};
		for (k = 0; k < 200; k++) begin
			@(posedge clk);
			wr <= 4'($urandom);
			wd <= 4'($urandom);
			@(negedge clk);
			chk(st, es);
			es = (es & ~wr) | (wd & wr);
		end
		for (k = 0; k < 200; k++) begin
			@(posedge clk);
			wr <= 4'h0;
			alt <= 11'($urandom);
			gout <= 11'($urandom);
			gdir <= 11'($urandom);
			req <= 4'($urandom);
			ev <= 1'($urandom);
			ext <= 11'($urandom);
			@(posedge clk);
			@(negedge clk);
			g = gexp(alt, gdir, gout, req, ev);
			chk(oe & GPIO_USED, g[21:11] & GPIO_USED);
			chk(o & g[21:11] & GPIO_USED, g[10:0] & g[21:11] & GPIO_USED);
			@(negedge clk);
			chk(inv & GPIO_USED, pin_i & GPIO_USED);
		end
		@(posedge clk);
		alt <= 11'h385;
		for (k = 0; k < 2; k++) begin
			// let an irq edge left by the random pin traffic drain first
			repeat (8) @(posedge clk);
			slow <= 1'(k);
			irq_cmd <= 1'b1;
			wait_req(1'b1);
			chk(irqs, 1'b1);
			wait_req(1'b0);
			@(posedge clk);
			irq_cmd <= 1'b0;
			repeat (3) @(negedge clk);
			chk({irqs, rreq}, 2'h0);
		end
		@(posedge clk);
		act <= 1'b1;
		gap(k);
		gap(k);
		chk(16'(k), 16'(SMB_HALF));
		@(posedge clk);
		act <= 1'b0;
		repeat (400) @(negedge clk);
		chk(scl, 1'b1);
		@(posedge clk);
		resetn <= 1'b0;
		@(negedge clk);
		chk({st, scl, mn}, 6'h02);
		@(posedge clk);
		resetn <= 1'b1;
		// straps recaptured on the first edge after release
		repeat (2) @(negedge clk);
		chk({st, lra, mr}, {ds, ds, ds, us, 1'b1, 1'b1});
		end_sim;
	end
endmodule
`default_nettype wire
